// ### rtl/hrpm_key_list.sv
`timescale 1ns/1ps
module hrpm_key_list #(
  parameter int unsigned SEGMENTS = hrpm_pkg::NUM_SEGMENTS,
  parameter int unsigned BYTES    = hrpm_pkg::SEG_BYTES
) (
  input  wire logic    clk_sys,
  input  wire logic    rst_n,
  hrpm_list_if.store   list
);

  typedef struct packed {
    logic [SEGMENTS*BYTES-1:0][7:0] mem;
  } hrpm_list_state_t;

  hrpm_list_state_t list_q;
  hrpm_list_state_t list_d;

  logic       seg_ok;
  logic [9:0] flat_idx;

  // ----------------------------------------------------------------
  // Segmented window onto one flat byte array
  // ----------------------------------------------------------------
  assign seg_ok   = 32'(list.seg) < SEGMENTS;
  assign flat_idx = 10'(list.seg * BYTES) + 10'(list.idx);

  // An invalid segment must neither alias another one nor wrap around.
  assign list.rdata = seg_ok ? list_q.mem[flat_idx] : 8'h00;

  always_comb
  begin
    list_d = list_q;
    if (list.wr && seg_ok)
    begin
      list_d.mem[flat_idx] = list.wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      list_q <= '0;
    end
    else
    begin
      list_q <= list_d;
    end
  end

endmodule : hrpm_key_list

// ### rtl/hrpm_list_if.sv
`timescale 1ns/1ps
interface hrpm_list_if;
  logic       wr;
  logic [2:0] seg;
  logic [6:0] idx;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport owner (output wr, output seg, output idx, output wdata, input rdata);
  modport store (input wr, input seg, input idx, input wdata, output rdata);
endinterface : hrpm_list_if

// ### rtl/hrpm_pkg.sv
package hrpm_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int unsigned NUM_PORTS    = 4;
  localparam int unsigned KEY_BITS     = 40;
  localparam int unsigned NUM_SEGMENTS = 5;
  localparam int unsigned SEG_BYTES    = 128;

  // ----------------------------------------------------------------
  // Repeater map offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_RX_KEY     = 8'h00;
  localparam logic [7:0] OFF_RX_KEY_MSB = 8'h04;
  localparam logic [7:0] OFF_TX_KEY     = 8'h10;
  localparam logic [7:0] OFF_TX_KEY_MSB = 8'h14;
  localparam logic [7:0] OFF_CAPS       = 8'h40;
  localparam logic [7:0] OFF_STAT_LO    = 8'h41;
  localparam logic [7:0] OFF_STAT_HI    = 8'h42;
  localparam logic [7:0] OFF_LIST_CTRL  = 8'h71;
  localparam logic [7:0] OFF_SELECT     = 8'h79;
  localparam logic [7:0] OFF_WINDOW     = 8'h80;

  // ----------------------------------------------------------------
  // Status map offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_FLAGS      = 8'h88;
  localparam logic [7:0] OFF_FLAG_CLR   = 8'h8A;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned LIST_DONE_BIT  = 7;
  localparam int unsigned SEL_AUTO_BIT   = 3;
  localparam int unsigned SEL_INVALID_BIT = 2;
  localparam int unsigned SEG_LSB        = 4;
  localparam int unsigned CAPS_READY_BIT = 5;
  localparam int unsigned FLAG_PORT_A    = 3;
  localparam logic [7:0]  CAPS_RESET     = 8'h83;
  localparam logic [7:0]  SELECT_RESET   = 8'h08;
  localparam logic [15:0] STATUS_RESET   = 16'h0000;
  localparam logic [2:0]  SEG_LIMIT      = 3'h5;

endpackage : hrpm_pkg

// ### rtl/hrpm_port_map.sv
`timescale 1ns/1ps
// Contract
// - One sticky key-written flag per port, A at bit 3 down to D at bit 0.
// - A flag stays set until the io bus writes that port's clear bit at 0x8A or a soft reset clears all flags.
// - Key, capability and status registers are kept per input port.
// - Auto select on (reset) views the active port, else the manual selector.
// - Manual selector 0..3 picks ports A..D, reset 0, only with auto off.
// - Receiver key readable in five bytes at 0x00..0x04 once ROM read succeeded.
// - Transmitter key stored at 0x10..0x14, reads zero until written.
// - Capability byte at 0x40 resets to 0x83, host may overwrite.
// - Status word at 0x41/0x42 clears only at power-up reset.
// - Key list is five 128-byte segments chosen by select bits 6:4.
// - Offsets 0x80..0xFF reach bytes 0..127 of the chosen segment.
// - Setting list-done starts hashing, then sets capability bit 5.
// - A transmitter write to key byte 0x14 clears capability bit 5.
module hrpm_port_map (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        soft_rst,
  input  wire logic [1:0]  active_port,
  input  wire logic        key_rom_ok,
  input  wire logic [39:0] key_rom_vector,
  input  wire logic        host_wr,
  input  wire logic        host_rd,
  input  wire logic [7:0]  host_addr,
  input  wire logic [7:0]  host_wdata,
  output logic      [7:0]  host_rdata,
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  input  wire logic [7:0]  io_addr,
  input  wire logic [7:0]  io_wdata,
  output logic      [7:0]  io_rdata,
  input  wire logic        ddc_wr,
  input  wire logic        ddc_rd,
  input  wire logic [1:0]  ddc_port,
  input  wire logic [7:0]  ddc_addr,
  input  wire logic [7:0]  ddc_wdata,
  output logic      [7:0]  ddc_rdata,
  output logic             list_done,
  output logic             hash_start,
  input  wire logic        hash_done
);

  localparam int unsigned NP = hrpm_pkg::NUM_PORTS;

  typedef struct packed {
    logic [NP-1:0][39:0] tx_key;
    logic [NP-1:0][7:0]  caps;
    logic [NP-1:0][15:0] status;
    logic [NP-1:0]       flags;
    logic [7:0]          select;
    logic                list_done;
    logic                hash_start;
    logic [7:0]          host_rdata;
    logic [7:0]          io_rdata;
    logic [7:0]          ddc_rdata;
  } hrpm_state_t;

  hrpm_state_t q;
  hrpm_state_t d;

  logic [1:0] view_port;
  logic       view_ok;
  logic       key_write;
  logic [7:0] view_caps;

  hrpm_list_if list ();

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [2:0] byte_sel(input logic [7:0] addr, input logic [7:0] base);
    logic [7:0] diff;
    diff     = addr - base;
    byte_sel = diff[2:0];
  endfunction : byte_sel

  function automatic logic [1:0] flag_pos(input logic [1:0] port);
    flag_pos = 2'(hrpm_pkg::FLAG_PORT_A) - port;
  endfunction : flag_pos

  // One read decoder serves both the host view and each transmitter's own port.
  function automatic logic [7:0] port_read(input hrpm_state_t s, input logic [1:0] p,
                                           input logic [7:0] addr, input logic rom_ok,
                                           input logic [39:0] rom_key);
    port_read = 8'h00;
    if (addr >= hrpm_pkg::OFF_RX_KEY && addr <= hrpm_pkg::OFF_RX_KEY_MSB && rom_ok)
    begin
      port_read = rom_key[8*byte_sel(addr, hrpm_pkg::OFF_RX_KEY) +: 8];
    end
    else if (addr >= hrpm_pkg::OFF_TX_KEY && addr <= hrpm_pkg::OFF_TX_KEY_MSB)
    begin
      port_read = s.tx_key[p][8*byte_sel(addr, hrpm_pkg::OFF_TX_KEY) +: 8];
    end
    else if (addr == hrpm_pkg::OFF_CAPS)
    begin
      port_read = s.caps[p];
    end
    else if (addr == hrpm_pkg::OFF_STAT_LO)
    begin
      port_read = s.status[p][7:0];
    end
    else if (addr == hrpm_pkg::OFF_STAT_HI)
    begin
      port_read = s.status[p][15:8];
    end
  endfunction : port_read

  // ----------------------------------------------------------------
  // Port view and key list window
  // ----------------------------------------------------------------
  assign view_port = q.select[hrpm_pkg::SEL_AUTO_BIT] ? active_port : q.select[1:0];
  // Manual codes 100..111 name no port, so port registers read zero and ignore host writes.
  assign view_ok   = q.select[hrpm_pkg::SEL_AUTO_BIT] || !q.select[hrpm_pkg::SEL_INVALID_BIT];
  assign view_caps = q.caps[view_port];
  assign key_write = ddc_wr && ddc_addr == hrpm_pkg::OFF_TX_KEY_MSB;

  assign list.wr    = host_wr && host_addr >= hrpm_pkg::OFF_WINDOW && !soft_rst;
  assign list.seg   = q.select[hrpm_pkg::SEG_LSB +: 3];
  assign list.idx   = 7'(host_addr - hrpm_pkg::OFF_WINDOW);
  assign list.wdata = host_wdata;

  hrpm_key_list u_key_list (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .list    (list)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    d            = q;
    d.hash_start = 1'b0;
    d.host_rdata = 8'h00;
    d.io_rdata   = 8'h00;
    d.ddc_rdata  = 8'h00;
    if (soft_rst)
    begin
      // Status words survive every reset but power-up.
      d.tx_key    = '0;
      d.caps      = {NP{hrpm_pkg::CAPS_RESET}};
      d.flags     = '0;
      d.select    = hrpm_pkg::SELECT_RESET;
      d.list_done = 1'b0;
    end
    else
    begin
      if (host_rd)
      begin
        if (host_addr >= hrpm_pkg::OFF_WINDOW)
        begin
          d.host_rdata = list.rdata;
        end
        else if (host_addr == hrpm_pkg::OFF_SELECT)
        begin
          d.host_rdata = q.select;
        end
        else if (host_addr == hrpm_pkg::OFF_LIST_CTRL)
        begin
          d.host_rdata = {q.list_done, 7'h00};
        end
        else if (view_ok)
        begin
          d.host_rdata = port_read(q, view_port, host_addr, key_rom_ok, key_rom_vector);
        end
      end
      if (io_rd && io_addr == hrpm_pkg::OFF_FLAGS)
      begin
        d.io_rdata = {4'h0, q.flags};
      end
      if (ddc_rd)
      begin
        d.ddc_rdata = port_read(q, ddc_port, ddc_addr, key_rom_ok, key_rom_vector);
      end
      if (host_wr)
      begin
        if (host_addr >= hrpm_pkg::OFF_TX_KEY && host_addr <= hrpm_pkg::OFF_TX_KEY_MSB && view_ok)
        begin
          d.tx_key[view_port][8*byte_sel(host_addr, hrpm_pkg::OFF_TX_KEY) +: 8] = host_wdata;
        end
        else if (host_addr == hrpm_pkg::OFF_CAPS && view_ok)
        begin
          d.caps[view_port] = host_wdata;
        end
        else if (host_addr == hrpm_pkg::OFF_STAT_LO && view_ok)
        begin
          d.status[view_port][7:0] = host_wdata;
        end
        else if (host_addr == hrpm_pkg::OFF_STAT_HI && view_ok)
        begin
          d.status[view_port][15:8] = host_wdata;
        end
        else if (host_addr == hrpm_pkg::OFF_SELECT)
        begin
          d.select = host_wdata;
        end
        else if (host_addr == hrpm_pkg::OFF_LIST_CTRL)
        begin
          d.list_done = host_wdata[hrpm_pkg::LIST_DONE_BIT];
          // Only a 0 to 1 step restarts hashing; rewriting 1 is a no-op.
          d.hash_start = host_wdata[hrpm_pkg::LIST_DONE_BIT] && !q.list_done;
        end
      end
      if (hash_done)
      begin
        d.caps[active_port][hrpm_pkg::CAPS_READY_BIT] = 1'b1;
      end
      if (io_wr && io_addr == hrpm_pkg::OFF_FLAG_CLR)
      begin
        d.flags = q.flags & ~io_wdata[NP-1:0];
      end
      if (ddc_wr && ddc_addr >= hrpm_pkg::OFF_TX_KEY && ddc_addr <= hrpm_pkg::OFF_TX_KEY_MSB)
      begin
        d.tx_key[ddc_port][8*byte_sel(ddc_addr, hrpm_pkg::OFF_TX_KEY) +: 8] = ddc_wdata;
      end
      // The key write comes last so it beats both a flag clear and a hash finish.
      if (key_write)
      begin
        d.flags[flag_pos(ddc_port)]                = 1'b1;
        d.caps[ddc_port][hrpm_pkg::CAPS_READY_BIT] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q            <= '0;
      q.caps       <= {NP{hrpm_pkg::CAPS_RESET}};
      q.status     <= {NP{hrpm_pkg::STATUS_RESET}};
      q.select     <= hrpm_pkg::SELECT_RESET;
    end
    else
    begin
      q <= d;
    end
  end

  assign host_rdata = q.host_rdata;
  assign io_rdata   = q.io_rdata;
  assign ddc_rdata  = q.ddc_rdata;
  assign list_done  = q.list_done;
  assign hash_start = q.hash_start;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_flag_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (key_write && ddc_port == 2'h0 && !soft_rst) |=> q.flags[hrpm_pkg::FLAG_PORT_A])
    else $error("port A flag not set by key write");

  a_flag_sticky: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (q.flags[0] && !soft_rst && !(io_wr && io_addr == hrpm_pkg::OFF_FLAG_CLR && io_wdata[0]))
    |=> q.flags[0])
    else $error("port D flag dropped without clear");

  a_flag_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (io_wr && io_addr == hrpm_pkg::OFF_FLAG_CLR && io_wdata[1]
     && !(key_write && ddc_port == 2'h2)) |=> !q.flags[1])
    else $error("port C flag survived clear");

  a_ready_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (key_write && !soft_rst) |=> !q.caps[$past(ddc_port)][hrpm_pkg::CAPS_READY_BIT])
    else $error("ready bit not cleared by key write");

  a_hash_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (host_wr && host_addr == hrpm_pkg::OFF_LIST_CTRL && host_wdata[hrpm_pkg::LIST_DONE_BIT]
     && !q.list_done
     && !soft_rst) |=> hash_start && list_done ##1 !hash_start)
    else $error("hash start not a single pulse");

  a_window_invalid: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (host_rd && host_addr >= hrpm_pkg::OFF_WINDOW && list.seg >= hrpm_pkg::SEG_LIMIT)
    |=> host_rdata == 8'h00)
    else $error("invalid segment read not zero");

  a_view_caps: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (host_rd && host_addr == hrpm_pkg::OFF_CAPS && view_ok && !soft_rst)
    |=> host_rdata == $past(view_caps))
    else $error("capability read from wrong port");

  a_status_kept: assert property (@(posedge clk_sys) disable iff (!rst_n)
    soft_rst |=> q.status == $past(q.status))
    else $error("status lost on soft reset");

  a_rx_key_hidden: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (host_rd && host_addr == hrpm_pkg::OFF_RX_KEY && !key_rom_ok) |=> host_rdata == 8'h00)
    else $error("receiver key visible before ROM read");

endmodule : hrpm_port_map

// ### tb/hrpm_hash_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Hash engine stand-in
// ----------------------------------------------------------------
module hrpm_hash_model (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       hash_start,
  input  wire logic [7:0] lag,
  output logic            hash_done
);
  logic [7:0] cnt_q;
  logic       busy_q;

  // A real engine needs many cycles, so the lag is changed between requests to try prompt and slow answers.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q     <= 8'h00;
      busy_q    <= 1'b0;
      hash_done <= 1'b0;
    end
    else
    begin
      hash_done <= 1'b0;
      if (hash_start)
      begin
        busy_q <= 1'b1;
        cnt_q  <= lag;
      end
      else if (busy_q && cnt_q == 8'h00)
      begin
        hash_done <= 1'b1;
        busy_q    <= 1'b0;
      end
      else if (busy_q)
        cnt_q <= cnt_q - 8'h01;
    end
  end
endmodule : hrpm_hash_model

// ### tb/test_hrpm_port_map.sv
`timescale 1ns/1ps
module test_hrpm_port_map;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        soft_rst = 1'b0;
  logic [1:0]  active_port = 2'h0;
  logic        key_rom_ok = 1'b1;
  logic [39:0] key_rom_vector = 40'h00_0000_0000;
  logic        host_wr = 1'b0, host_rd = 1'b0, io_wr = 1'b0;
  logic        io_rd = 1'b0, ddc_wr = 1'b0, ddc_rd = 1'b0;
  logic [7:0]  host_addr = 8'h00, host_wdata = 8'h00, io_addr = 8'h00;
  logic [7:0]  io_wdata = 8'h00, ddc_addr = 8'h00, ddc_wdata = 8'h00;
  logic [1:0]  ddc_port = 2'h0;
  logic [7:0]  lag = 8'h03;
  logic [7:0]  host_rdata, io_rdata, ddc_rdata;
  logic        list_done, hash_start, hash_done;
  logic [7:0]  qh[$], qi[$], qd[$];
  logic        ph = 1'b0, pi = 1'b0, pd = 1'b0;
  logic [5:0]  st = 6'h00;
  int          err_total = 0, checks = 0, hcnt = 0;
  logic [31:0] seed = 32'h7442_3f75;
  logic [39:0] key [4];
  logic [7:0]  stat [4];
  logic [7:0]  lst [5][2];

  always #5 clk_sys = ~clk_sys;

  hrpm_port_map uut (.clk_sys(clk_sys), .rst_n(rst_n), .soft_rst(soft_rst),
    .active_port(active_port), .key_rom_ok(key_rom_ok), .key_rom_vector(key_rom_vector),
    .host_wr(host_wr), .host_rd(host_rd), .host_addr(host_addr), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .io_wr(io_wr), .io_rd(io_rd), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .ddc_wr(ddc_wr), .ddc_rd(ddc_rd),
    .ddc_port(ddc_port), .ddc_addr(ddc_addr), .ddc_wdata(ddc_wdata), .ddc_rdata(ddc_rdata),
    .list_done(list_done), .hash_start(hash_start), .hash_done(hash_done));

  hrpm_hash_model u_hash (.clk_sys(clk_sys), .rst_n(rst_n), .hash_start(hash_start),
    .lag(lag), .hash_done(hash_done));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic test_done();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done

  task automatic cmp8(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp8

  // Strobes are gathered in st and driven once per edge, so none is assigned twice in a step.
  task automatic tick();
    {host_wr, host_rd, io_wr, io_rd, ddc_wr, ddc_rd} <= st;
    st = 6'h00;
    @(posedge clk_sys);
  endtask : tick

  task automatic hb(input logic w, input logic [7:0] a, input logic [7:0] d);
    st[5:4] = {w, !w};
    host_addr  <= a;
    host_wdata <= d;
    if (!w)
      qh.push_back(d);
    tick();
  endtask : hb

  task automatic ib(input logic w, input logic [7:0] a, input logic [7:0] d, input logic t);
    st[3:2] = {w, !w};
    io_addr  <= a;
    io_wdata <= d;
    if (!w)
      qi.push_back(d);
    if (t)
      tick();
  endtask : ib

  task automatic db(input logic w, input logic [1:0] p, input logic [7:0] a,
                    input logic [7:0] d);
    st[1:0] = {w, !w};
    ddc_port  <= p;
    ddc_addr  <= a;
    ddc_wdata <= d;
    if (!w)
      qd.push_back(d);
    tick();
  endtask : db

  task automatic wait_done();
    int i;
    for (i = 0; i < 100; i++)
    begin
      tick();
      if (hash_done === 1'b1)
        break;
    end
    if (i == 100)
    begin
      err_total++;
      test_done();
    end
  endtask : wait_done

  // ----------------------------------------------------------------
  // Read-back monitor
  // ----------------------------------------------------------------
  always @(posedge clk_sys)
  begin
    if (ph)
      cmp8("host_rdata", qh.pop_front(), host_rdata);
    if (pi)
      cmp8("io_rdata", qi.pop_front(), io_rdata);
    if (pd)
      cmp8("ddc_rdata", qd.pop_front(), ddc_rdata);
    ph <= host_rd;
    pi <= io_rd;
    pd <= ddc_rd;
    if (hash_start === 1'b1)
      hcnt++;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    int p;
    int s;
    key_rom_vector <= {8'(rnd()), rnd()};
    for (p = 0; p < 4; p++)
      key[p] = {8'(rnd()), rnd()};
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    tick();
    hb(0, 8'h40, 8'h83);
    hb(0, 8'h79, 8'h08);
    hb(0, 8'h42, 8'h00);
    hb(0, 8'h14, 8'h00);
    ib(0, 8'h88, 8'h00, 1);
    hb(0, 8'h50, 8'h00);
    for (p = 0; p < 5; p++)
      hb(0, 8'(p), key_rom_vector[8*p +: 8]);
    hb(1, 8'h02, 8'hFF);
    hb(0, 8'h02, key_rom_vector[23:16]);
    key_rom_ok <= 1'b0;
    hb(0, 8'h00, 8'h00);
    db(0, 2'h1, 8'h04, 8'h00);
    key_rom_ok <= 1'b1;
    for (p = 0; p < 4; p++)
    begin
      active_port <= 2'(p);
      stat[p] = 8'(rnd());
      hb(1, 8'h40, 8'hE0 | 8'(p));
      hb(1, 8'h41, stat[p]);
    end
    for (p = 0; p < 4; p++)
    begin
      for (s = 0; s < 5; s++)
        db(1, 2'(p), 8'h10 + 8'(s), key[p][8*s +: 8]);
      ib(0, 8'h88, 8'h0F & (8'h0F << (3 - p)), 1);
      db(0, 2'(p), 8'h10, key[p][7:0]);
      db(0, 2'(p), 8'h03, key_rom_vector[31:24]);
    end
    for (p = 0; p < 4; p++)
    begin
      hb(1, 8'h79, 8'(p));
      hb(0, 8'h40, 8'hC0 | 8'(p));
      hb(0, 8'h41, stat[p]);
      hb(0, 8'h14, key[p][39:32]);
    end
    hb(1, 8'h79, 8'h04);
    hb(0, 8'h40, 8'h00);
    active_port <= 2'h2;
    hb(1, 8'h79, 8'h08);
    hb(0, 8'h40, 8'hC2);
    repeat (5) tick();
    ib(0, 8'h88, 8'h0F, 1);
    ib(1, 8'h8A, 8'h0C, 0);
    db(1, 2'h0, 8'h14, key[0][39:32]);
    ib(0, 8'h88, 8'h0B, 1);
    ib(1, 8'h8A, 8'h0B, 1);
    ib(0, 8'h88, 8'h00, 1);
    hb(1, 8'h71, 8'h80);
    wait_done();
    hb(0, 8'h40, 8'hE2);
    cmp8("list_done", 8'h01, {7'h00, list_done});
    lag <= 8'h14;
    db(1, 2'h2, 8'h14, key[2][39:32]);
    hb(0, 8'h40, 8'hC2);
    hb(1, 8'h71, 8'h00);
    hb(1, 8'h71, 8'h80);
    wait_done();
    hb(0, 8'h40, 8'hE2);
    cmp8("hash_start count", 8'h02, 8'(hcnt));
    for (s = 0; s < 5; s++)
    begin
      lst[s][0] = 8'(rnd());
      lst[s][1] = 8'(rnd());
      hb(1, 8'h79, 8'h08 | 8'(s << 4));
      hb(1, 8'h80, lst[s][0]);
      hb(1, 8'hFF, lst[s][1]);
    end
    hb(1, 8'h79, 8'h58);
    hb(1, 8'h80, 8'h5A);
    hb(0, 8'h80, 8'h00);
    for (s = 0; s < 5; s++)
    begin
      hb(1, 8'h79, 8'h08 | 8'(s << 4));
      hb(0, 8'h80, lst[s][0]);
      hb(0, 8'hFF, lst[s][1]);
    end
    soft_rst <= 1'b1;
    tick();
    soft_rst <= 1'b0;
    tick();
    hb(0, 8'h41, stat[2]);
    hb(0, 8'h40, 8'h83);
    hb(1, 8'h79, 8'h48);
    hb(0, 8'h80, lst[4][0]);
    // The last read is compared one edge later, so let it land before reset.
    tick();
    rst_n <= 1'b0;
    tick();
    rst_n <= 1'b1;
    tick();
    hb(0, 8'h41, 8'h00);
    repeat (3) tick();
    test_done();
  end
endmodule : test_hrpm_port_map
